// File: src/op_decode_pkg.sv
package op_decode_pkg;
	localparam logic [7:0] OP_NOP = 8'h0f;
	localparam logic [7:0] OP_OR_FIRST = 8'h42;
	localparam logic [7:0] OP_OR_LAST = 8'h47;
	localparam logic [7:0] OP_ORX_EE = 8'h48;
	localparam logic [7:0] OP_ORX_EI = 8'h49;
	localparam logic [7:0] OP_POP = 8'h50;
	localparam logic [7:0] OP_LDX_A_FIRST = 8'h84;
	localparam logic [7:0] OP_LDX_A_LAST = 8'h89;
	localparam logic [7:0] OP_LDX_B_FIRST = 8'h94;
	localparam logic [7:0] OP_LDX_B_LAST = 8'h97;
	localparam logic [7:0] OP_LEA_R = 8'h98;
	localparam logic [7:0] OP_LEA_RR = 8'h99;
	localparam logic [7:0] OP_LDX_EE = 8'he8;
	localparam logic [7:0] OP_LDX_EI = 8'he9;
	localparam logic [7:0] OP_MUL = 8'hf4;
	localparam logic [7:0] SP_STEP = 8'h01;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	// addressing modes
	typedef enum logic [3:0] {
		MODE_NONE = 4'h0,
		MODE_WORK = 4'h1,
		MODE_WORK_IND = 4'h2,
		MODE_REG = 4'h3,
		MODE_REG_IND = 4'h4,
		MODE_PAIR = 4'h5,
		MODE_WORK_PAIR = 4'h6,
		MODE_PAIR_IND = 4'h7,
		MODE_INDEXED = 4'h8,
		MODE_INDEXED_PAIR = 4'h9,
		MODE_EXT = 4'ha,
		MODE_IMM = 4'hb,
		MODE_STACK = 4'hc
	} addr_mode_t;
	// per-flag policy: 0 keep, 1 result, 2 clear, 3 set
	typedef enum logic [1:0] {
		FP_KEEP = 2'h0,
		FP_RESULT = 2'h1,
		FP_CLEAR = 2'h2,
		FP_SET = 2'h3
	} flag_pol_t;
	typedef enum logic [2:0] {
		OPK_NONE = 3'h0,
		OPK_COPY = 3'h1,
		OPK_ADDR = 3'h2,
		OPK_MUL = 3'h3,
		OPK_OR = 3'h4,
		OPK_POP = 3'h5
	} op_kind_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} dec_state_t;
endpackage : op_decode_pkg

// File: src/op_exec_unit.sv
`timescale 1ns/10ps
module op_exec_unit
	import op_decode_pkg::*;
(
	input wire logic [2:0] kind,
	input wire logic [15:0] dstVal,
	input wire logic [7:0] srcVal,
	input wire logic [7:0] disp,
	input wire logic [7:0] stackPtr,
	output logic [15:0] result,
	output logic [7:0] nextStackPtr,
	output logic zeroOut,
	output logic signOut
);
	always_comb begin
		result = dstVal;
		nextStackPtr = stackPtr;
		case (op_kind_t'(kind))
			OPK_COPY: result = {8'h00, srcVal};
			OPK_ADDR: result = dstVal + {{8{disp[7]}}, disp};
			OPK_MUL: result = dstVal[15:8] * dstVal[7:0];
			OPK_OR: result = {8'h00, dstVal[7:0] | srcVal};
			OPK_POP: begin
				result = {8'h00, srcVal};
				nextStackPtr = stackPtr + SP_STEP;
			end
			default: result = dstVal;
		endcase
		zeroOut = (result[7:0] == 8'h00);
		signOut = result[7];
	end
endmodule : op_exec_unit

// File: src/cpu_load_logic_op_decoder.sv
// Overview of operation
// - Extended loads 84-89, 94-97, e8, e9 copy source to destination with flags untouched.
// - Effective address load 98/99 writes destination value plus signed offset, 3 bytes, 3 or 5 cycles.
// - Opcode f4 multiplies high by low byte of a pair into 16 bits, 2 bytes, 8 cycles.
// - Opcode 0f is a one-byte no-op taking 2 cycles.
// - OR 42-47 writes dst or src, zero and sign from result, overflow cleared, rest kept.
// - OR costs: working forms 2 bytes 3/4 cycles, register forms 3 bytes 3/4 cycles.
// - Extended OR 48/49 flags as short OR, 4 bytes, 3 cycles.
// - The pop bumps the stack pointer by one after the read.
// - Flag policy codes: keep, result, clear, set; undefined is treated as keep.
`timescale 1ns/10ps
module cpu_load_logic_op_decoder
	import op_decode_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic opValid,
	input wire logic [7:0] opcode,
	input wire logic [15:0] dstVal,
	input wire logic [7:0] srcVal,
	input wire logic [7:0] disp,
	input wire logic [7:0] stackPtr,
	output logic busy,
	output logic known,
	output logic [3:0] dstMode,
	output logic [3:0] srcMode,
	output logic [2:0] fetchBytes,
	output logic [3:0] execCycles,
	output logic [1:0] polCarry,
	output logic [1:0] polZero,
	output logic [1:0] polSign,
	output logic [1:0] polOver,
	output logic [1:0] polDec,
	output logic [1:0] polHalf,
	output logic wrEn,
	output logic wide,
	output logic [15:0] result,
	output logic spWrEn,
	output logic [7:0] newStackPtr,
	output logic flagWrEn,
	output logic [3:0] flagMask,
	output logic [3:0] flagVal
);
	// decoded fields of one opcode
	typedef struct packed {
		logic hit;
		addr_mode_t dm;
		addr_mode_t sm;
		logic [2:0] bytes;
		logic [3:0] cyc;
		logic isOr;
		op_kind_t kind;
		logic wideWr;
	} dec_t;

	function automatic dec_t decode(input logic [7:0] op);
		dec_t d;
		d = '{hit: 1'b1, dm: MODE_NONE, sm: MODE_NONE, bytes: 3'h3, cyc: 4'h2,
			isOr: 1'b0, kind: OPK_COPY, wideWr: 1'b0};
		case (op)
			8'h84: begin d.dm = MODE_WORK; d.sm = MODE_EXT; d.cyc = 4'h2; end
			8'h85: begin d.dm = MODE_WORK_IND; d.sm = MODE_EXT; d.cyc = 4'h3; end
			8'h86: begin d.dm = MODE_REG; d.sm = MODE_PAIR_IND; d.cyc = 4'h4; end
			8'h87: begin d.dm = MODE_REG_IND; d.sm = MODE_PAIR_IND; d.cyc = 4'h5; end
			8'h88: begin d.dm = MODE_WORK; d.sm = MODE_INDEXED_PAIR; d.cyc = 4'h4; end
			8'h89: begin d.dm = MODE_INDEXED_PAIR; d.sm = MODE_WORK; d.cyc = 4'h4; end
			8'h94: begin d.dm = MODE_EXT; d.sm = MODE_WORK; d.cyc = 4'h2; end
			8'h95: begin d.dm = MODE_EXT; d.sm = MODE_WORK_IND; d.cyc = 4'h3; end
			8'h96: begin d.dm = MODE_PAIR_IND; d.sm = MODE_REG; d.cyc = 4'h4; end
			8'h97: begin d.dm = MODE_PAIR_IND; d.sm = MODE_REG_IND; d.cyc = 4'h5; end
			OP_LDX_EE: begin d.dm = MODE_EXT; d.sm = MODE_EXT; d.bytes = 3'h4; end
			OP_LDX_EI: begin d.dm = MODE_EXT; d.sm = MODE_IMM; d.bytes = 3'h4; end
			OP_LEA_R: begin
				d.dm = MODE_WORK; d.sm = MODE_INDEXED; d.cyc = 4'h3; d.kind = OPK_ADDR;
			end
			OP_LEA_RR: begin
				d.dm = MODE_WORK_PAIR; d.sm = MODE_INDEXED_PAIR; d.cyc = 4'h5;
				d.kind = OPK_ADDR; d.wideWr = 1'b1;
			end
			OP_MUL: begin
				d.dm = MODE_PAIR; d.bytes = 3'h2; d.cyc = 4'h8; d.kind = OPK_MUL;
				d.wideWr = 1'b1;
			end
			OP_NOP: begin d.bytes = 3'h1; d.kind = OPK_NONE; end
			8'h42: begin d.dm = MODE_WORK; d.sm = MODE_WORK; d.bytes = 3'h2; d.cyc = 4'h3; end
			8'h43: begin d.dm = MODE_WORK; d.sm = MODE_WORK_IND; d.bytes = 3'h2; d.cyc = 4'h4; end
			8'h44: begin d.dm = MODE_REG; d.sm = MODE_REG; d.cyc = 4'h3; end
			8'h45: begin d.dm = MODE_REG; d.sm = MODE_REG_IND; d.cyc = 4'h4; end
			8'h46: begin d.dm = MODE_REG; d.sm = MODE_IMM; d.cyc = 4'h3; end
			8'h47: begin d.dm = MODE_REG_IND; d.sm = MODE_IMM; d.cyc = 4'h4; end
			OP_ORX_EE: begin d.dm = MODE_EXT; d.sm = MODE_EXT; d.bytes = 3'h4; d.cyc = 4'h3; end
			OP_ORX_EI: begin d.dm = MODE_EXT; d.sm = MODE_IMM; d.bytes = 3'h4; d.cyc = 4'h3; end
			OP_POP: begin
				d.dm = MODE_REG; d.sm = MODE_STACK; d.bytes = 3'h2; d.kind = OPK_POP;
			end
			default: begin
				d.hit = 1'b0; d.bytes = 3'h1; d.cyc = 4'h1; d.kind = OPK_NONE;
			end
		endcase
		if ((op >= OP_OR_FIRST && op <= OP_OR_LAST) || op == OP_ORX_EE || op == OP_ORX_EI) begin
			d.isOr = 1'b1;
			d.kind = OPK_OR;
		end
		return d;
	endfunction : decode

	dec_t dec;
	logic [15:0] exResult;
	logic [7:0] exSp;
	logic exZero;
	logic exSign;
	dec_state_t state, next_state;
	logic [3:0] count, next_count;
	logic next_busy, next_known, next_wrEn, next_wide, next_spWrEn, next_flagWrEn;
	logic [3:0] next_dstMode, next_srcMode, next_execCycles, next_flagMask, next_flagVal;
	logic [2:0] next_fetchBytes;
	logic [1:0] next_polZ, next_polS, next_polV;
	logic [15:0] next_result;
	logic [7:0] next_newSp;

	assign dec = decode(opcode);

	op_exec_unit exec (
		.kind(dec.kind),
		.dstVal(dstVal),
		.srcVal(srcVal),
		.disp(disp),
		.stackPtr(stackPtr),
		.result(exResult),
		.nextStackPtr(exSp),
		.zeroOut(exZero),
		.signOut(exSign)
	);

	// outputs other than busy and the one-cycle write strobes hold from acceptance until the next opcode is accepted
	always_comb begin
		next_state = state;
		next_count = count;
		next_busy = busy;
		next_known = known;
		next_dstMode = dstMode;
		next_srcMode = srcMode;
		next_fetchBytes = fetchBytes;
		next_execCycles = execCycles;
		next_polZ = polZero;
		next_polS = polSign;
		next_polV = polOver;
		next_result = result;
		next_newSp = newStackPtr;
		next_wrEn = 1'b0;
		next_wide = wide;
		next_spWrEn = 1'b0;
		next_flagWrEn = 1'b0;
		next_flagMask = flagMask;
		next_flagVal = flagVal;
		case (state)
			ST_IDLE: begin
				if (opValid) begin
					next_known = dec.hit;
					next_dstMode = dec.dm;
					next_srcMode = dec.sm;
					next_fetchBytes = dec.bytes;
					next_execCycles = dec.cyc;
					next_result = exResult;
					next_newSp = exSp;
					next_wide = dec.wideWr;
					next_wrEn = dec.hit && (dec.kind != OPK_NONE);
					next_spWrEn = (dec.kind == OPK_POP);
					// flag order in mask/val: zero, sign, overflow, carry
					next_polZ = dec.isOr ? FP_RESULT : FP_KEEP;
					next_polS = dec.isOr ? FP_RESULT : FP_KEEP;
					next_polV = dec.isOr ? FP_CLEAR : FP_KEEP;
					next_flagWrEn = dec.isOr;
					next_flagMask = dec.isOr ? 4'h7 : 4'h0;
					next_flagVal = dec.isOr ? {1'b0, 1'b0, exSign, exZero} : 4'h0;
					if (dec.cyc > 4'h1) begin
						next_state = ST_BUSY;
						next_busy = 1'b1;
						next_count = dec.cyc - 4'h1;
					end
				end
			end
			ST_BUSY: begin
				next_count = count - 4'h1;
				if (count == 4'h1) begin
					next_state = ST_IDLE;
					next_busy = 1'b0;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
			count <= 4'h0;
			busy <= 1'b0;
			known <= 1'b0;
			dstMode <= MODE_NONE;
			srcMode <= MODE_NONE;
			fetchBytes <= 3'h0;
			execCycles <= 4'h0;
			polZero <= FP_KEEP;
			polSign <= FP_KEEP;
			polOver <= FP_KEEP;
			result <= 16'h0000;
			newStackPtr <= 8'h00;
			wrEn <= 1'b0;
			wide <= 1'b0;
			spWrEn <= 1'b0;
			flagWrEn <= 1'b0;
			flagMask <= FLAGS_RESET;
			flagVal <= FLAGS_RESET;
		end else begin
			state <= next_state;
			count <= next_count;
			busy <= next_busy;
			known <= next_known;
			dstMode <= next_dstMode;
			srcMode <= next_srcMode;
			fetchBytes <= next_fetchBytes;
			execCycles <= next_execCycles;
			polZero <= next_polZ;
			polSign <= next_polS;
			polOver <= next_polV;
			result <= next_result;
			newStackPtr <= next_newSp;
			wrEn <= next_wrEn;
			wide <= next_wide;
			spWrEn <= next_spWrEn;
			flagWrEn <= next_flagWrEn;
			flagMask <= next_flagMask;
			flagVal <= next_flagVal;
		end
	end

	// carry, decimal and half carry are never touched in this slice
	always_comb begin
		polCarry = FP_KEEP;
		polDec = FP_KEEP;
		polHalf = FP_KEEP;
	end

	sequence s_take(logic [7:0] op);
		opValid && !busy && opcode == op;
	endsequence

	a_mul_cost: assert property (@(posedge mclk) disable iff (rst)
		s_take(OP_MUL) |=> fetchBytes == 3'h2 && execCycles == 4'h8 && busy[*7] ##1 !busy)
		else $error("multiply cost wrong");
	a_mul_value: assert property (@(posedge mclk) disable iff (rst)
		s_take(OP_MUL) |=> wrEn && wide && result == $past(dstVal[15:8]) * $past(dstVal[7:0]))
		else $error("multiply product wrong");
	a_nop_cost: assert property (@(posedge mclk) disable iff (rst)
		s_take(OP_NOP) |=> fetchBytes == 3'h1 && !wrEn && !flagWrEn && busy ##1 !busy)
		else $error("nop cost wrong");
	a_or_flags: assert property (@(posedge mclk) disable iff (rst)
		opValid && !busy && opcode >= OP_OR_FIRST && opcode <= OP_ORX_EI
		|=> flagWrEn && flagMask == 4'h7 && flagVal[2] == 1'b0
		&& flagVal[0] == (result[7:0] == 8'h00) && flagVal[1] == result[7])
		else $error("or flags wrong");
	a_or_cost: assert property (@(posedge mclk) disable iff (rst)
		s_take(8'h43) |=> fetchBytes == 3'h2 && execCycles == 4'h4)
		else $error("or indirect cost wrong");
	a_orx_cost: assert property (@(posedge mclk) disable iff (rst)
		s_take(OP_ORX_EI) |=> fetchBytes == 3'h4 && execCycles == 4'h3)
		else $error("extended or cost wrong");
	a_pop_sp: assert property (@(posedge mclk) disable iff (rst)
		s_take(OP_POP) |=> spWrEn && newStackPtr == $past(stackPtr) + 8'h01 && !flagWrEn)
		else $error("pop pointer wrong");
	a_lea_cost: assert property (@(posedge mclk) disable iff (rst)
		s_take(OP_LEA_RR) |=> execCycles == 4'h5 && fetchBytes == 3'h3 && !flagWrEn)
		else $error("lea cost wrong");
	a_ldx_flags: assert property (@(posedge mclk) disable iff (rst)
		s_take(OP_LDX_EE) |=> fetchBytes == 3'h4 && !flagWrEn && result[7:0] == $past(srcVal))
		else $error("extended load wrong");
	a_pol_code: assert property (@(posedge mclk) disable iff (rst)
		flagWrEn |-> polOver == FP_CLEAR && polZero == FP_RESULT)
		else $error("flag policy wrong");
endmodule : cpu_load_logic_op_decoder

// File: dv/core_fetch_model.sv
`timescale 1ns/10ps
module core_fetch_model
	import op_decode_pkg::*;
(
	input wire logic mclk,
	input wire logic busy,
	output logic opValid,
	output logic [7:0] opcode,
	output logic [15:0] dstVal,
	output logic [7:0] srcVal,
	output logic [7:0] disp,
	output logic [7:0] stackPtr
);
	initial begin
		opValid = 1'b0;
		{opcode, dstVal, srcVal, disp, stackPtr} = '0;
	end
	// request and operands held until the take edge; a slow core idles first
	task automatic issue(input logic [47:0] v, input logic slow);
		int n;
		n = 0;
		if (slow) @(posedge mclk);
		if (slow) #1;
		{opcode, dstVal, srcVal, disp, stackPtr} = v;
		opValid = 1'b1;
		@(posedge mclk);
		while (busy !== 1'b0 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		opValid <= 1'b0;
		// released operands flip, so stale values are never trusted
		{opcode, dstVal, srcVal, disp, stackPtr} <= ~v;
		#1;
	endtask : issue
	// a request while the decoder is busy, expected to be ignored
	task automatic poke(input logic [7:0] op);
		opcode = op;
		opValid = 1'b1;
		@(posedge mclk);
		opValid <= 1'b0;
		#1;
	endtask : poke
endmodule : core_fetch_model

// File: dv/testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %0t got %h want %h", $time, g, e); end end
module testbench;
	import op_decode_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	int miscompares = 0;
	int checks_done = 0;
	logic [15:0] rnd = 16'he177;
	logic opValid, busy, known, wrEn, wide, spWrEn, flagWrEn;
	logic [7:0] opcode, srcVal, disp, stackPtr, newStackPtr;
	logic [15:0] dstVal, result;
	logic [3:0] dstMode, srcMode, execCycles, flagMask, flagVal;
	logic [2:0] fetchBytes;
	logic [1:0] polCarry, polZero, polSign, polOver, polDec, polHalf;
	logic [7:0] ops [27] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h94, 8'h95, 8'h96,
		8'h97, 8'he8, 8'he9, 8'h98, 8'h99, 8'hf4, 8'h0f, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46,
		8'h47, 8'h48, 8'h49, 8'h50, 8'h51, 8'h00};
	always #2.5 mclk = ~mclk;
	core_fetch_model core_fetch_model_i (.mclk, .busy, .opValid, .opcode, .dstVal, .srcVal,
		.disp, .stackPtr);
	cpu_load_logic_op_decoder cpu_load_logic_op_decoder_i (.mclk, .rst, .opValid, .opcode,
		.dstVal, .srcVal, .disp, .stackPtr, .busy, .known, .dstMode, .srcMode, .fetchBytes,
		.execCycles, .polCarry, .polZero, .polSign, .polOver, .polDec, .polHalf, .wrEn, .wide,
		.result, .spWrEn, .newStackPtr, .flagWrEn, .flagMask, .flagVal);
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	// {known, fetch bytes, cycles}
	function automatic logic [7:0] cost(input logic [7:0] op);
		case (op)
			8'h84, 8'h94: return 8'hb2;
			8'h85, 8'h95, 8'h98, 8'h44, 8'h46: return 8'hb3;
			8'h86, 8'h88, 8'h89, 8'h96, 8'h45, 8'h47: return 8'hb4;
			8'h87, 8'h97, 8'h99: return 8'hb5;
			8'he8, 8'he9: return 8'hc2;
			8'h48, 8'h49: return 8'hc3;
			8'hf4: return 8'ha8;
			8'h0f: return 8'h92;
			8'h42: return 8'ha3;
			8'h43: return 8'ha4;
			8'h50: return 8'ha2;
			default: return 8'h11;
		endcase
	endfunction : cost
	task automatic report_and_stop();
		if (miscompares == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	task automatic do_op(input logic [47:0] v, input logic slow, input logic poke);
		logic [7:0] op, s, x, p, r, c;
		logic [15:0] d, res;
		logic [2:0] wexp;
		logic isOr;
		int n;
		{op, d, s, x, p} = v;
		c = cost(op);
		isOr = op inside {[8'h42:8'h49]};
		r = d[7:0] | s;
		res = {8'h00, s};
		if (op == OP_LEA_R) res = {8'h00, d[7:0] + x};
		if (op == OP_LEA_RR) res = d + {{8{x[7]}}, x};
		if (op == OP_MUL) res = d[15:8] * d[7:0];
		if (isOr) res = {8'h00, r};
		wexp = {c[7] && op != OP_NOP, op == OP_POP, isOr};
		core_fetch_model_i.issue(v, slow);
		`CHK({known, fetchBytes, execCycles}, c);
		`CHK({wrEn, spWrEn, flagWrEn}, wexp);
		`CHK({polCarry, polDec, polHalf}, 6'h00);
		`CHK({polZero, polSign, polOver}, isOr ? 6'h16 : 6'h00);
		if (wexp[2]) `CHK({wide, wide ? result : {8'h00, result[7:0]}},
			{op inside {OP_LEA_RR, OP_MUL}, res});
		if (isOr) `CHK({flagMask, flagVal[2:0]}, {4'h7, 1'b0, r[7], r == 8'h00});
		if (wexp[1]) `CHK(newStackPtr, p + SP_STEP);
		if (op inside {8'h46, 8'h47, OP_ORX_EI, OP_LDX_EI}) `CHK(srcMode, MODE_IMM);
		if (op inside {OP_ORX_EE, OP_LDX_EE}) `CHK({dstMode, srcMode}, 8'haa);
		n = 1;
		if (poke) begin
			core_fetch_model_i.poke(OP_OR_FIRST);
			n = 2;
			`CHK({busy, wrEn, result}, {2'b10, res});
		end
		while (busy === 1'b1 && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
			if (n == 2) `CHK({wrEn, spWrEn, flagWrEn}, 3'h0);
		end
		`CHK(n, int'(c[3:0]));
	endtask : do_op
	initial begin
		logic [15:0] a, b;
		repeat (3) @(posedge mclk);
		#1;
		rst = 1'b0;
		// corners: zero and sign results, stack wrap, negative offset, top product
		do_op({OP_OR_FIRST, 16'h0000, 8'h00, 8'h00, 8'h00}, 1'b0, 1'b0);
		do_op({8'h44, 16'h0001, 8'h80, 8'h00, 8'h00}, 1'b0, 1'b0);
		do_op({OP_POP, 16'h0000, 8'h5a, 8'h00, 8'hff}, 1'b0, 1'b0);
		do_op({OP_LEA_RR, 16'h0100, 8'h00, 8'h80, 8'h00}, 1'b0, 1'b0);
		do_op({OP_MUL, 16'hffff, 8'h00, 8'h00, 8'h00}, 1'b0, 1'b1);
		do_op({8'h51, 16'h1234, 8'h56, 8'h00, 8'h00}, 1'b0, 1'b0);
		do_op({8'h00, 16'h1234, 8'h56, 8'h00, 8'h00}, 1'b0, 1'b0);
		for (int i = 0; i < 120; i++) begin
			rnd = lfsr(rnd);
			a = rnd;
			rnd = lfsr(rnd);
			b = rnd;
			rnd = lfsr(rnd);
			do_op({ops[a % 27], b, rnd[7:0], rnd[15:8], a[15:8]}, rnd[3], 1'b0);
		end
		report_and_stop();
	end
	// a few hundred cycles expected; far beyond that means a hang
	initial begin
		#100000;
		miscompares++;
		report_and_stop();
	end
endmodule : testbench
